//--- sram_mask_pkg.sv
// constants, types and helpers for the masked burst-write sram core
// assumes a single clock domain; the controller drives all inputs synchronously
package sram_mask_pkg;

  localparam int DEF_DATA_W     = 18;
  localparam int DEF_ADDR_W     = 20;
  localparam int NIBBLE_LANE_W  = 4;
  localparam int BYTE_LANE_W    = 9;
  localparam int WIDE_LANES     = 4;
  localparam int PAIR_LANES     = 2;
  localparam int SINGLE_LANES   = 1;

  // burst counter bit for each half of the burst
  localparam logic BURST_FIRST_LSB  = 1'b0;
  localparam logic BURST_SECOND_LSB = 1'b1;

  // read outputs come up released (deselected)
  localparam logic OE_RESET = 1'b0;

  // cycles from the command edge to data capture or to the read beat
  localparam int WRITE_DATA_DELAY = 1;
  localparam int READ_DATA_DELAY  = 1;

  typedef enum logic [1:0] {
    PORT_IDLE,
    PORT_WRITE,
    PORT_READ
  } port_state_t;

  typedef struct packed {
    logic loadStrobeN;
    logic readWriteN;
  } cmd_t;

  function automatic int laneCount(input int dataW);
    case (dataW)
      8:       laneCount = PAIR_LANES;
      9:       laneCount = SINGLE_LANES;
      18:      laneCount = PAIR_LANES;
      36:      laneCount = WIDE_LANES;
      default: laneCount = SINGLE_LANES;
    endcase
  endfunction : laneCount

  function automatic bit widthOk(input int dataW);
    widthOk = (dataW == 8) || (dataW == 9) || (dataW == 18) || (dataW == 36);
  endfunction : widthOk

endpackage : sram_mask_pkg

//--- lane_enable.sv
// expands active-low lane selects into a per-bit write enable
// assumes LANES * LANE_W == DATA_W
module lane_enable
  import sram_mask_pkg::*;
#(
  parameter int DATA_W = DEF_DATA_W,
  parameter int LANES  = laneCount(DEF_DATA_W),
  parameter int LANE_W = DEF_DATA_W / laneCount(DEF_DATA_W)
) (
  // lane selects, low writes the lane
  input  wire logic [LANES-1:0]  laneMaskN,
  // one enable per data bit
  output logic      [DATA_W-1:0] bitEnable
);

  if (LANES * LANE_W != DATA_W) begin : g_bad
    $error("lane_enable: lanes do not tile the data word");
  end

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign bitEnable[l*LANE_W +: LANE_W] = {LANE_W{~laneMaskN[l]}};
  end

endmodule : lane_enable

//--- ddr_sram_byte_write_mask.sv
// burst sram core with per-lane write masking, 8/9/18/36-bit organisations
// assumes the controller presents both halves of a double-rate beat together,
// one clock after the command, with a separate mask for each half
//
// Behaviour
// R1 - 8/18-bit: both selects low writes every lane of the word.
// R2 - 18-bit: select0 low only writes bits 8..0, keeps 17..9.
// R3 - 18-bit: select1 low only writes bits 17..9, keeps 8..0.
// R4 - 8-bit: selects gate nibbles 3..0 and 7..4 independently.
// R5 - 8/18-bit: both selects high leaves the addressed word unchanged.
// R6 - 9-bit: single select gates all nine bits.
// R7 - 36-bit: four selects each gate one 9-bit lane.
// R8 - 9/36-bit: all selects high writes nothing for that half.
// R9 - masks are taken separately for each half and may differ.
// R10 - write data taken on both halves; read data driven out.
// R11 - after reset the port is deselected with outputs released.
// R12 - 18/36-bit: first word at latched address, second at burst address.
// R13 - 8/9-bit: first word at address with low bit 0, second with 1.
// R14 - burst timing counted from the command cycle and its successors.
// R15 - controller should park clocks at equal levels when stopping them.
// R16 - controller starts a write with load and direction low.
// R17 - data and masks captured the cycle after the address cycle.
// R18 - lane count and lane width follow the organisation width.
module ddr_sram_byte_write_mask
  import sram_mask_pkg::*;
#(
  parameter int DATA_W = DEF_DATA_W,
  parameter int ADDR_W = DEF_ADDR_W,
  parameter int LANES  = laneCount(DEF_DATA_W)
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // command and address
  input  wire cmd_t              cmd,
  input  wire logic [ADDR_W-1:0] addr,
  // write data, first and second half of the burst
  input  wire logic [DATA_W-1:0] wrDataRise,
  input  wire logic [DATA_W-1:0] wrDataFall,
  input  wire logic [LANES-1:0]  laneMaskRiseN,
  input  wire logic [LANES-1:0]  laneMaskFallN,
  // read data
  output logic      [DATA_W-1:0] rdDataRise,
  output logic      [DATA_W-1:0] rdDataFall,
  output logic                   rdDataOe
);

  localparam int  LANE_W = DATA_W / LANES;                     // R18
  localparam bit  NARROW = (DATA_W <= BYTE_LANE_W);
  localparam int  ARR_AW = NARROW ? ADDR_W + 1 : ADDR_W;
  localparam int  DEPTH  = 1 << ARR_AW;
  localparam int  WR_LAT = WRITE_DATA_DELAY;
  localparam int  RD_LAT = READ_DATA_DELAY;

  // nibble lanes only make sense for the 8-bit part
  if (!widthOk(DATA_W) || LANES != laneCount(DATA_W) || ADDR_W < 2 ||
      LANE_W != ((DATA_W == 8) ? NIBBLE_LANE_W : BYTE_LANE_W)) begin : g_chk // R18
    $error("ddr_sram_byte_write_mask: unsupported organisation");
  end

  // array storage; no reset, contents are undefined until written
  logic [DATA_W-1:0] mem [DEPTH];

  port_state_t       state_r;
  port_state_t       state_nxt;
  logic [ADDR_W-1:0] latchAddr_r;
  logic [ARR_AW-1:0] firstBeatAddr;
  logic [ARR_AW-1:0] secondBeatAddr;
  logic [DATA_W-1:0] enRise;
  logic [DATA_W-1:0] enFall;
  logic [DATA_W-1:0] oldFirst;
  logic [DATA_W-1:0] oldSecond;

  // command decode: a write or read owns the following cycle
  always_comb begin
    state_nxt = PORT_IDLE;
    if (!cmd.loadStrobeN) begin                                // R14
      state_nxt = cmd.readWriteN ? PORT_READ : PORT_WRITE;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= PORT_IDLE;                                    // R11
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      latchAddr_r <= '0;
    end else if (!cmd.loadStrobeN) begin
      latchAddr_r <= addr;
    end
  end

  // burst addressing: narrow parts append the counter bit, wide parts
  // flip the external low bit so the pair always lands on distinct words
  if (NARROW) begin : g_narrow
    assign firstBeatAddr  = {latchAddr_r, BURST_FIRST_LSB};    // R13
    assign secondBeatAddr = {latchAddr_r, BURST_SECOND_LSB};   // R13
  end else begin : g_wide
    assign firstBeatAddr  = latchAddr_r;                       // R12
    assign secondBeatAddr = {latchAddr_r[ADDR_W-1:1], ~latchAddr_r[0]}; // R12
  end

  // each half has its own mask decode
  lane_enable #(
    .DATA_W (DATA_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_en_rise (
    .laneMaskN (laneMaskRiseN),
    .bitEnable (enRise)
  );

  lane_enable #(
    .DATA_W (DATA_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_en_fall (
    .laneMaskN (laneMaskFallN),                                // R9
    .bitEnable (enFall)
  );

  assign oldFirst  = mem[firstBeatAddr];
  assign oldSecond = mem[secondBeatAddr];

  // merge of one burst word: deselected lanes keep their stored bits
  function automatic logic [DATA_W-1:0] laneMerge(input logic [DATA_W-1:0] old,
                                                  input logic [DATA_W-1:0] data,
                                                  input logic [DATA_W-1:0] en);
    laneMerge = (old & ~en) | (data & en);
  endfunction : laneMerge

  // masked write: deselected lanes keep their stored bits
  always_ff @(posedge clk) begin
    if (state_r == PORT_WRITE) begin                           // R17
      mem[firstBeatAddr]  <= laneMerge(oldFirst, wrDataRise, enRise);    // R1 R2 R3 R4 R5 R6 R7 R8
      mem[secondBeatAddr] <= laneMerge(oldSecond, wrDataFall, enFall);   // R9 R10
    end
  end

  // read path: no posted-write bypass, since the write lands on its beat edge
  // and a read of that word the cycle after sees the new contents
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdDataOe   <= OE_RESET;                                  // R11
      rdDataRise <= '0;
      rdDataFall <= '0;
    end else begin
      case (state_r)
        PORT_READ: begin
          rdDataOe   <= 1'b1;                                  // R10
          rdDataRise <= oldFirst;
          rdDataFall <= oldSecond;
        end
        default: begin
          rdDataOe   <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_write_cmd;
    !cmd.loadStrobeN && !cmd.readWriteN;
  endsequence

  sequence s_write_beat;
    state_r == PORT_WRITE && latchAddr_r == $past(addr);
  endsequence

  property p_write_timing;
    s_write_cmd |-> ##WR_LAT s_write_beat;
  endproperty
  a_write_timing: assert property (p_write_timing)             // R14 R17
    else $error("write beat not one cycle after command");

  property p_merge_first;
    state_r == PORT_WRITE |=> mem[$past(firstBeatAddr)] ===
      (($past(oldFirst) & ~$past(enRise)) | ($past(wrDataRise) & $past(enRise)));
  endproperty
  a_merge_first: assert property (p_merge_first)               // R2 R3 R4 R6 R7
    else $error("first half masked merge wrong");

  property p_merge_second;
    state_r == PORT_WRITE |=> mem[$past(secondBeatAddr)] ===
      (($past(oldSecond) & ~$past(enFall)) | ($past(wrDataFall) & $past(enFall)));
  endproperty
  a_merge_second: assert property (p_merge_second)             // R9
    else $error("second half masked merge wrong");

  property p_full_write;
    state_r == PORT_WRITE && laneMaskRiseN == '0 |=> mem[$past(firstBeatAddr)] === $past(wrDataRise);
  endproperty
  a_full_write: assert property (p_full_write)                 // R1
    else $error("full mask did not write every lane");

  property p_no_write;
    state_r == PORT_WRITE && (&laneMaskFallN) |=> mem[$past(secondBeatAddr)] === $past(oldSecond);
  endproperty
  a_no_write: assert property (p_no_write)                     // R5 R8
    else $error("all selects high altered the word");

  property p_lane0_enable;
    !laneMaskRiseN[0] |-> enRise[LANE_W-1:0] == '1 && (LANES == 1 || !enRise[DATA_W-1] || !laneMaskRiseN[LANES-1]);
  endproperty
  a_lane0_enable: assert property (p_lane0_enable)             // R18
    else $error("lane 0 enable decode wrong");

  property p_burst_pair;
    secondBeatAddr == {firstBeatAddr[ARR_AW-1:1], ~firstBeatAddr[0]};
  endproperty
  a_burst_pair: assert property (p_burst_pair)                 // R12 R13
    else $error("burst addresses are not a pair");

  if (NARROW) begin : g_narrow_chk
    property p_narrow_even;
      firstBeatAddr[0] == BURST_FIRST_LSB && firstBeatAddr[ARR_AW-1:1] == latchAddr_r;
    endproperty
    a_narrow_even: assert property (p_narrow_even)             // R13
      else $error("narrow first beat not at even word");
  end

  property p_read_out;
    state_r == PORT_READ |=> rdDataOe && rdDataRise === $past(oldFirst) && rdDataFall === $past(oldSecond);
  endproperty
  a_read_out: assert property (p_read_out)                     // R10
    else $error("read data not driven one cycle after read");

  property p_deselect;
    state_r != PORT_READ |=> !rdDataOe;
  endproperty
  a_deselect: assert property (p_deselect)                     // R11
    else $error("outputs enabled without a read");

  sequence s_read_cmd;
    !cmd.loadStrobeN && cmd.readWriteN;
  endsequence

  sequence s_read_beat;
    state_r == PORT_READ;
  endsequence

  property p_read_latency;
    s_read_cmd |-> ##RD_LAT s_read_beat ##1 rdDataOe;
  endproperty
  a_read_latency: assert property (p_read_latency)             // R14
    else $error("read data not out two cycles after command");

  property p_oe_source;
    rdDataOe |-> $past(state_r) == PORT_READ;
  endproperty
  a_oe_source: assert property (p_oe_source)                   // R11
    else $error("outputs enabled with no read beat before");

  property p_nop_idle;
    cmd.loadStrobeN |=> state_r == PORT_IDLE;
  endproperty
  a_nop_idle: assert property (p_nop_idle)                     // R14
    else $error("no-op command started a burst");

  property p_addr_hold;
    cmd.loadStrobeN |=> $stable(latchAddr_r);
  endproperty
  a_addr_hold: assert property (p_addr_hold)                   // R12
    else $error("latched address moved without a command");

  property p_rd_hold;
    state_r != PORT_READ |=> $stable(rdDataRise) && $stable(rdDataFall);
  endproperty
  a_rd_hold: assert property (p_rd_hold)                       // R10
    else $error("read data changed without a read");

  property p_array_quiet;
    state_r != PORT_WRITE |=> mem[$past(firstBeatAddr)] === $past(oldFirst) &&
      mem[$past(secondBeatAddr)] === $past(oldSecond);
  endproperty
  a_array_quiet: assert property (p_array_quiet)               // R14
    else $error("array word changed outside a write beat");

  // per-lane checks taken straight from the selects, not from the decode
  for (genvar l = 0; l < LANES; l++) begin : g_lane_chk
    property p_lane_rise_wr;
      state_r == PORT_WRITE && !laneMaskRiseN[l] |=>
        mem[$past(firstBeatAddr)][l*LANE_W +: LANE_W] === $past(wrDataRise[l*LANE_W +: LANE_W]);
    endproperty
    a_lane_rise_wr: assert property (p_lane_rise_wr)           // R2 R3 R4 R6 R7
      else $error("selected first-half lane not written");

    property p_lane_rise_keep;
      state_r == PORT_WRITE && laneMaskRiseN[l] |=>
        mem[$past(firstBeatAddr)][l*LANE_W +: LANE_W] === $past(oldFirst[l*LANE_W +: LANE_W]);
    endproperty
    a_lane_rise_keep: assert property (p_lane_rise_keep)       // R5 R8
      else $error("deselected first-half lane altered");

    property p_lane_fall_wr;
      state_r == PORT_WRITE && !laneMaskFallN[l] |=>
        mem[$past(secondBeatAddr)][l*LANE_W +: LANE_W] === $past(wrDataFall[l*LANE_W +: LANE_W]);
    endproperty
    a_lane_fall_wr: assert property (p_lane_fall_wr)           // R9 R17
      else $error("selected second-half lane not written");

    property p_lane_fall_keep;
      state_r == PORT_WRITE && laneMaskFallN[l] |=>
        mem[$past(secondBeatAddr)][l*LANE_W +: LANE_W] === $past(oldSecond[l*LANE_W +: LANE_W]);
    endproperty
    a_lane_fall_keep: assert property (p_lane_fall_keep)       // R9
      else $error("deselected second-half lane altered");
  end

endmodule : ddr_sram_byte_write_mask

//--- burst_ctrl_model.sv
// controller model: drives commands, burst data and lane masks of the core
// assumes the core samples every input on the rising clk edge
module burst_ctrl_model
  import sram_mask_pkg::*;
#(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 4,
  parameter int LANES  = 2
) (
  // clock
  input  wire logic              clk,
  // command and address
  output cmd_t                   cmd,
  output logic      [ADDR_W-1:0] addr,
  // burst data and masks
  output logic      [DATA_W-1:0] wrDataRise,
  output logic      [DATA_W-1:0] wrDataFall,
  output logic      [LANES-1:0]  laneMaskRiseN,
  output logic      [LANES-1:0]  laneMaskFallN
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cmd = '{loadStrobeN: 1'b1, readWriteN: 1'b1};
    addr = '0;
    wrDataRise = '0;
    wrDataFall = '0;
    laneMaskRiseN = '1;
    laneMaskFallN = '1;
  end

  // released lines flip so a stale value never looks valid
  task automatic park();
    cmd = '{loadStrobeN: 1'b1, readWriteN: 1'b1};
    addr = ~addr;
    wrDataRise = ~wrDataRise;
    wrDataFall = ~wrDataFall;
    laneMaskRiseN = ~laneMaskRiseN;
    laneMaskFallN = ~laneMaskFallN;
  endtask : park

  task automatic doWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] r, f,
                         input logic [LANES-1:0] mr, mf);
    @(posedge clk);
    #1;
    cmd = '{loadStrobeN: 1'b0, readWriteN: 1'b0};
    addr = a;
    @(posedge clk);
    #1;
    cmd.loadStrobeN = 1'b1;
    addr = ~a;
    wrDataRise = r;
    wrDataFall = f;
    laneMaskRiseN = mr;
    laneMaskFallN = mf;
    @(posedge clk);
    #1;
    park();
  endtask : doWrite

  // leaves the command up so calls run back to back
  task automatic doRead(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    #1;
    cmd = '{loadStrobeN: 1'b0, readWriteN: 1'b1};
    addr = a;
  endtask : doRead
endmodule : burst_ctrl_model

//--- ddr_sram_byte_write_mask_test.sv
// self-checking bench for the masked burst core: 18-bit in depth, 8/9/36-bit briefly
// assumes burst_ctrl_model drives every command and data input
module ddr_sram_byte_write_mask_test
  import sram_mask_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DW = 18;
  localparam int AW = 4;
  logic            clk;
  logic            sys_rst;
  cmd_t            cmd;
  logic [AW-1:0]   addr;
  logic [DW-1:0]   wrDataRise;
  logic [DW-1:0]   wrDataFall;
  logic [DW-1:0]   rdDataRise;
  logic [DW-1:0]   rdDataFall;
  logic [DW-1:0]   refMem [16];
  logic [1:0]      laneMaskRiseN;
  logic [1:0]      laneMaskFallN;
  logic            rdDataOe;
  logic [2*DW-1:0] expQ [$];
  int              checks = 0;
  int              badCount = 0;
  int              cycles = 0;

  ddr_sram_byte_write_mask #(.DATA_W(DW), .ADDR_W(AW), .LANES(2)) ddr_sram_byte_write_mask_inst (
    .clk, .sys_rst, .cmd, .addr, .wrDataRise, .wrDataFall, .laneMaskRiseN, .laneMaskFallN,
    .rdDataRise, .rdDataFall, .rdDataOe);
  burst_ctrl_model #(.DATA_W(DW), .ADDR_W(AW), .LANES(2)) burst_ctrl_model_inst (
    .clk, .cmd, .addr, .wrDataRise, .wrDataFall, .laneMaskRiseN, .laneMaskFallN);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cmp(input logic [71:0] got, exp);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic giveVerdict();
    $display("checks=%0d bad=%0d", checks, badCount);
    if (badCount == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : giveVerdict

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, d, input logic [1:0] m);
    for (int l = 0; l < 2; l++) if (!m[l]) old[l*9 +: 9] = d[l*9 +: 9];
    return old;
  endfunction : merge

  // second word lands on the address with bit 0 flipped
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] r, f, input logic [1:0] mr, mf);
    burst_ctrl_model_inst.doWrite(a, r, f, mr, mf);
    refMem[a] = merge(refMem[a], r, mr);
    refMem[{a[AW-1:1], ~a[0]}] = merge(refMem[{a[AW-1:1], ~a[0]}], f, mf);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a);
    expQ.push_back({refMem[a], refMem[{a[AW-1:1], ~a[0]}]});
    burst_ctrl_model_inst.doRead(a);
  endtask : rd

  // other organisations: fill a pair, rewrite the first half under a random
  // mask and the second with every select high, then read the pair back
  for (genvar k = 0; k < 3; k++) begin : g_org
    localparam int W  = (k == 0) ? 8 : (k == 1) ? 9 : 36;
    localparam int L  = (k == 2) ? 4 : (k == 1) ? 1 : 2;
    localparam int LW = W / L;
    cmd_t           oCmd;
    logic [AW-1:0]  oAddr;
    logic [W-1:0]   oWrRise;
    logic [W-1:0]   oWrFall;
    logic [L-1:0]   oMaskRiseN;
    logic [L-1:0]   oMaskFallN;
    logic [W-1:0]   oRdRise;
    logic [W-1:0]   oRdFall;
    logic           oOe;
    logic           done;
    logic [2*W-1:0] oExpQ [$];

    ddr_sram_byte_write_mask #(.DATA_W(W), .ADDR_W(AW), .LANES(L)) ddr_sram_byte_write_mask_inst (
      .clk, .sys_rst, .cmd(oCmd), .addr(oAddr), .wrDataRise(oWrRise), .wrDataFall(oWrFall),
      .laneMaskRiseN(oMaskRiseN), .laneMaskFallN(oMaskFallN), .rdDataRise(oRdRise),
      .rdDataFall(oRdFall), .rdDataOe(oOe));
    burst_ctrl_model #(.DATA_W(W), .ADDR_W(AW), .LANES(L)) burst_ctrl_model_inst (
      .clk, .cmd(oCmd), .addr(oAddr), .wrDataRise(oWrRise), .wrDataFall(oWrFall),
      .laneMaskRiseN(oMaskRiseN), .laneMaskFallN(oMaskFallN));

    function automatic logic [W-1:0] pick(input logic [W-1:0] old, d, input logic [L-1:0] m);
      for (int l = 0; l < L; l++) if (!m[l]) old[l*LW +: LW] = d[l*LW +: LW];
      return old;
    endfunction : pick

    always @(posedge clk) begin
      if (oOe === 1'b1) begin
        if (oExpQ.size() == 0) cmp(72'({oRdRise, oRdFall}), ~72'({oRdRise, oRdFall}));
        else cmp(72'({oRdRise, oRdFall}), 72'(oExpQ.pop_front()));
      end
    end

    initial begin
      logic [AW-1:0] a;
      logic [W-1:0]  r;
      logic [W-1:0]  f;
      logic [L-1:0]  m;
      done = 1'b0;
      @(negedge sys_rst);
      for (int i = 0; i < 6; i++) begin
        a = AW'($urandom);
        r = W'({$urandom, $urandom});
        f = W'({$urandom, $urandom});
        m = L'($urandom);
        burst_ctrl_model_inst.doWrite(a, ~r, f, '0, '0);
        burst_ctrl_model_inst.doWrite(a, r, ~f, m, '1);
        oExpQ.push_back({pick(~r, r, m), f});
        burst_ctrl_model_inst.doRead(a);
      end
      @(posedge clk);
      #1;
      burst_ctrl_model_inst.park();
      repeat (3) @(posedge clk);
      cmp(72'(oExpQ.size()), '0);
      $display("organisation of %0d bits done", W);
      done = 1'b1;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (rdDataOe === 1'b1) begin
      if (expQ.size() == 0) cmp({rdDataRise, rdDataFall}, ~{rdDataRise, rdDataFall});
      else cmp({rdDataRise, rdDataFall}, expQ.pop_front());
    end
    if (cycles == 1000) begin
      badCount++;
      giveVerdict();
    end
  end

  initial begin
    logic [AW-1:0] a;
    sys_rst = 1'b1;
    void'($urandom(2903));
    repeat (4) @(posedge clk);
    cmp({rdDataRise, rdDataFall} | rdDataOe, '0);
    #1;
    sys_rst = 1'b0;
    @(posedge clk);
    #1;
    cmp({rdDataRise, rdDataFall} | rdDataOe, '0);
    for (int i = 0; i < 16; i += 2) wr(AW'(i), DW'($urandom), DW'($urandom), 2'b00, 2'b00);
    for (int i = 0; i < 16; i++) rd(AW'(i));
    @(posedge clk);
    #1;
    burst_ctrl_model_inst.park();
    repeat (3) @(posedge clk);
    $display("fill and read-back done");
    for (int i = 0; i < 16; i++) begin
      a = AW'($urandom);
      wr(a, DW'($urandom), DW'($urandom), i[3:2], i[1:0]);
      rd(a);
    end
    @(posedge clk);
    #1;
    burst_ctrl_model_inst.park();
    repeat (3) @(posedge clk);
    $display("mask codes done");
    cmp(36'(expQ.size()), '0);
    wait (g_org[0].done === 1'b1 && g_org[1].done === 1'b1 && g_org[2].done === 1'b1);
    giveVerdict();
  end
endmodule : ddr_sram_byte_write_mask_test
